// [ddc_port_map.svh]
// register offsets, field positions, reset values and sizes of the output port block
`ifndef DDC_PORT_MAP_SVH
`define DDC_PORT_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define DDC_OFS_PORT_A_CTRL    8'h00
`define DDC_OFS_PORT_B_CTRL    8'h04
`define DDC_OFS_PORT_C_CTRL    8'h08
`define DDC_OFS_CLOCK_CTRL     8'h0C
`define DDC_OFS_STATUS         8'h10

// ************************************************************
// field positions
// ************************************************************
`define DDC_ENABLE_LSB         0
`define DDC_ENABLE_MSB         5
`define DDC_FORMAT_BIT         8
`define DDC_APPEND_BIT         9
`define DDC_MASTER_BIT         0
`define DDC_DIV_LSB            1
`define DDC_DIV_MSB            2
`define DDC_STATUS_REQ_LSB     24

// ************************************************************
// reset values and sizes
// ************************************************************
`define DDC_PORT_CTRL_RESET    10'h000
`define DDC_CLOCK_CTRL_RESET   3'h0
`define DDC_NUM_PORTS          3
`define DDC_NUM_STAGES         6
`define DDC_WORD_W             16

`endif

// [ddc_port_pkg.sv]
// types shared by the output port block
package ddc_port_pkg;

	// ************************************************************
	// port sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,     // nothing pending, request low
		ST_REQ,      // request high, waiting for acknowledge
		ST_WORD_A,   // first word (i, or i/q pair) on the bus
		ST_WORD_Q,   // q word on the bus (interleaved only)
		ST_WORD_G    // gain word on the bus
	} port_state_t;

endpackage : ddc_port_pkg

// [ddc_parallel_output_ports.sv]
// three output ports that stream stage samples and gain words, with an ahb-lite register slave
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ddc_port_map.svh"

// ************************************************************
// one output port: capture, arbitration and word sequencing
// ************************************************************
module ddc_out_port #(
	parameter int STAGES = 6,
	parameter int WORD_W = 16
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          tick,
	input  wire logic [STAGES-1:0]             enable,
	input  wire logic                          fmt_parallel,
	input  wire logic                          append_gain,
	input  wire logic [STAGES-1:0]             cap_valid,
	input  wire logic [STAGES-1:0][WORD_W-1:0] cap_i,
	input  wire logic [STAGES-1:0][WORD_W-1:0] cap_q,
	input  wire logic [STAGES-1:0][WORD_W-1:0] cap_g,
	input  wire logic                          ack,
	output logic                               req,
	output logic [WORD_W-1:0]                  data,
	output logic                               iq,
	output logic                               gw,
	output logic [2:0]                         src,
	output logic [STAGES-1:0]                  pending
);

	// elaboration guard: the index pins and the byte split fix these sizes
	if (STAGES < 1 || STAGES > 8 || WORD_W != 16) begin : g_bad_size
		$error("ddc_out_port: unsupported size");
	end

	logic [WORD_W-1:0]        buf_i_ff [STAGES];  // latest i per stage
	logic [WORD_W-1:0]        buf_q_ff [STAGES];  // latest q per stage
	logic [WORD_W-1:0]        buf_g_ff [STAGES];  // latest gain per stage
	logic [WORD_W-1:0]        cur_q_ff;           // q of the sample in flight
	logic [WORD_W-1:0]        cur_g_ff;           // gain of the sample in flight
	logic [WORD_W-1:0]        cur_i_ff;           // i of the sample in flight
	ddc_port_pkg::port_state_t state_ff;          // sequencer state
	ddc_port_pkg::port_state_t nxt_state;
	logic [STAGES-1:0]        cand;               // pending and enabled
	logic [2:0]               sel;                // winning stage
	logic                     take;               // sample leaves its buffer
	logic                     nxt_req;
	logic [WORD_W-1:0]        nxt_data;
	logic                     nxt_iq;
	logic                     nxt_gw;
	logic [2:0]               nxt_src;

	assign cand = pending & enable;

	// lowest index wins when several stages wait at once
	// fixed stage priority
	always_comb begin
		sel = 3'h0;
		for (int s = STAGES - 1; s >= 0; s--) begin
			if (cand[s]) begin
				sel = 3'(s);
			end
		end
	end

	// capture a stage sample whenever it arrives for an enabled stage
	// bypassed stages still deliver
	always_ff @(posedge clk) begin
		for (int s = 0; s < STAGES; s++) begin
			if (cap_valid[s] && enable[s]) begin
				buf_i_ff[s] <= cap_i[s];
				buf_q_ff[s] <= cap_q[s];
				buf_g_ff[s] <= cap_g[s];
			end
		end
	end

	// pending flags: a new arrival wins over the clear of a take
	// only enabled stages queue
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~((take ? STAGES'(1) : STAGES'(0)) << sel)) | (cap_valid & enable);
		end
	end

	// next-word selection; everything holds between port clock ticks
	always_comb begin
		nxt_state = state_ff;
		nxt_req   = req;
		nxt_data  = data;
		nxt_iq    = iq;
		nxt_gw    = gw;
		nxt_src   = src;
		take      = 1'b0;
		if (tick) begin
			unique case (state_ff)
				ddc_port_pkg::ST_IDLE: begin
					// raise request on a ready sample
					if (|cand) begin
						take      = 1'b1;
						nxt_req   = 1'b1;
						nxt_state = ddc_port_pkg::ST_REQ;
					end
				end
				ddc_port_pkg::ST_REQ: begin
					if (ack) begin
						// first word one tick after request
						// parallel: i byte high, q byte low; interleaved: whole i word
						nxt_data  = fmt_parallel ? {cur_i_ff[15:8], cur_q_ff[15:8]} : cur_i_ff;
						nxt_iq    = 1'b1;
						nxt_gw    = 1'b0;
						nxt_src   = src;
						nxt_state = ddc_port_pkg::ST_WORD_A;
					end
				end
				default: begin
					if (ack) begin
						if (state_ff == ddc_port_pkg::ST_WORD_A && !fmt_parallel) begin
							nxt_data  = cur_q_ff;
							nxt_iq    = 1'b0;
							nxt_state = ddc_port_pkg::ST_WORD_Q;
						end else if (state_ff != ddc_port_pkg::ST_WORD_G && append_gain) begin
							nxt_data  = cur_g_ff;
							nxt_iq    = 1'b0;
							nxt_gw    = 1'b1;
							nxt_state = ddc_port_pkg::ST_WORD_G;
						end else if (|cand) begin
							// request stays high while data waits
							take    = 1'b1;
							nxt_gw  = 1'b0;
							nxt_src = sel;
							if (fmt_parallel) begin
								// indicator stays high back to back
								nxt_data  = {buf_i_ff[sel][15:8], buf_q_ff[sel][15:8]};
								nxt_iq    = 1'b1;
								nxt_state = ddc_port_pkg::ST_WORD_A;
							end else begin
								nxt_data  = '0;
								nxt_iq    = 1'b0;
								nxt_state = ddc_port_pkg::ST_REQ;
							end
						end else begin
							nxt_req   = 1'b0;
							nxt_data  = '0;
							nxt_iq    = 1'b0;
							nxt_gw    = 1'b0;
							nxt_src   = 3'h0;
							nxt_state = ddc_port_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// pins change only on a port clock tick
	// outputs move on port clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ddc_port_pkg::ST_IDLE;
			req      <= 1'b0;
			data     <= '0;
			iq       <= 1'b0;
			gw       <= 1'b0;
			src      <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			req      <= nxt_req;
			data     <= nxt_data;
			iq       <= nxt_iq;
			gw       <= nxt_gw;
			// idle take latches the index early, so it already shows while request waits
			src      <= (take && state_ff == ddc_port_pkg::ST_IDLE) ? sel : nxt_src;
		end
	end

	// sample in flight; words pass unchanged so twos complement is kept
	// twos complement passthrough
	always_ff @(posedge clk) begin
		if (take) begin
			cur_i_ff <= buf_i_ff[sel];
			cur_q_ff <= buf_q_ff[sel];
			cur_g_ff <= buf_g_ff[sel];
		end
	end

endmodule : ddc_out_port

// Functional notes
// - three ports, sixteen-bit bus, shared clock
// - power up in slave clock mode
// - six enables per port select stages
// - bypassed stages still feed ports
// - format bit: interleaved or parallel
// - gain append bit per port
// - request on ready sample, acknowledge answers
// - i word first tick after request
// - i indicator high with i word
// - q word next, indicator low
// - index pins name the stage
// - interleaved gain after q, gain indicator
// - interleaved sample three or four ticks
// - parallel: i upper byte, q lower
// - parallel indicator high back to back
// - parallel gain after pair, indicator low
// - fixed priority, not arrival order, stage zero highest
// - master clock divided by 1/2/4/8
// - acknowledge sampled, low halts shifting
// - pins change on clock, request holds
// - data in twos complement
module ddc_parallel_output_ports #(
	parameter int STAGES = 6,
	parameter int WORD_W = 16
) (
	input  wire logic                                       hclk,
	input  wire logic                                       hresetn,
	input  wire logic                                       hsel,
	input  wire logic [31:0]                                haddr,
	input  wire logic [1:0]                                 htrans,
	input  wire logic                                       hwrite,
	input  wire logic [2:0]                                 hsize,
	input  wire logic [31:0]                                hwdata,
	input  wire logic                                       hready,
	output logic      [31:0]                                hrdata,
	output logic                                            hreadyout,
	output logic                                            hresp,
	input  wire logic [STAGES-1:0]                          stage_valid,
	input  wire logic [STAGES-1:0][WORD_W-1:0]              stage_i,
	input  wire logic [STAGES-1:0][WORD_W-1:0]              stage_q,
	input  wire logic [STAGES-1:0][WORD_W-1:0]              stage_gain,
	input  wire logic                                       pclk_in,
	output logic                                            pclk_out,
	output logic                                            pclk_oe_n,
	input  wire logic [`DDC_NUM_PORTS-1:0]                  port_acknowledge,
	output logic      [`DDC_NUM_PORTS-1:0]                  port_request,
	output logic      [`DDC_NUM_PORTS-1:0][WORD_W-1:0]      port_data_bus,
	output logic      [`DDC_NUM_PORTS-1:0]                  i_data_indicator,
	output logic      [`DDC_NUM_PORTS-1:0]                  gain_word_indicator,
	output logic      [`DDC_NUM_PORTS-1:0][2:0]             source_stage_index
);

	// ************************************************************
	// register bus slave
	// ************************************************************
	logic [9:0]                           port_ctrl_ff [`DDC_NUM_PORTS];  // enables, format, append
	logic [2:0]                           clock_ctrl_ff;                  // divisor and master bit
	logic [7:0]                           wr_addr_ff;                     // data-phase address
	logic                                 wr_pend_ff;                     // write in data phase
	logic [`DDC_NUM_PORTS-1:0][STAGES-1:0] pend;                          // per-port pending flags
	logic [31:0]                          nxt_rdata;
	logic                                 access;

	assign access = hsel && htrans[1] && hready;

	// read value chosen in the address phase so the data phase needs no wait
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			`DDC_OFS_PORT_A_CTRL: nxt_rdata = {22'h00_0000, port_ctrl_ff[0]};
			`DDC_OFS_PORT_B_CTRL: nxt_rdata = {22'h00_0000, port_ctrl_ff[1]};
			`DDC_OFS_PORT_C_CTRL: nxt_rdata = {22'h00_0000, port_ctrl_ff[2]};
			`DDC_OFS_CLOCK_CTRL:  nxt_rdata = {29'h0000_0000, clock_ctrl_ff};
			`DDC_OFS_STATUS:      nxt_rdata = {5'h00, port_request, 6'h00, pend[2], pend[1], pend[0]};
			default:              nxt_rdata = 32'h0000_0000;
		endcase
	end

	// address phase capture and read data; only whole words, so hsize is not decoded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_addr_ff <= 8'h00;
			wr_pend_ff <= 1'b0;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wr_pend_ff <= access && hwrite;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			if (access) begin
				wr_addr_ff <= haddr[7:0];
				if (!hwrite && haddr[31:8] == 24'h00_0000) begin
					hrdata <= nxt_rdata;
				end else if (!hwrite) begin
					hrdata <= 32'h0000_0000;
				end
			end
		end
	end

	// data phase writes decode only the low address byte; unmapped byte offsets are ignored
	// format bit per port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < `DDC_NUM_PORTS; p++) begin
				port_ctrl_ff[p] <= `DDC_PORT_CTRL_RESET;
			end
			clock_ctrl_ff <= `DDC_CLOCK_CTRL_RESET;
		end else if (wr_pend_ff) begin
			unique case (wr_addr_ff)
				`DDC_OFS_PORT_A_CTRL: port_ctrl_ff[0] <= hwdata[9:0];
				`DDC_OFS_PORT_B_CTRL: port_ctrl_ff[1] <= hwdata[9:0];
				`DDC_OFS_PORT_C_CTRL: port_ctrl_ff[2] <= hwdata[9:0];
				`DDC_OFS_CLOCK_CTRL:  clock_ctrl_ff   <= hwdata[2:0];
				default:              ;
			endcase
		end
	end

	// ************************************************************
	// port clock: divider in master mode, edge of the pin in slave mode
	// ************************************************************
	logic       master;
	logic [2:0] div_cnt_ff;   // position inside one port clock period
	logic [2:0] div_last;     // divisor minus one
	logic       pclk_prev_ff; // previous level of the incoming clock pin
	logic       tick;         // one hclk per port clock rising edge

	assign master   = clock_ctrl_ff[`DDC_MASTER_BIT];
	assign div_last = 3'((4'h1 << clock_ctrl_ff[`DDC_DIV_MSB:`DDC_DIV_LSB]) - 4'h1);
	assign tick     = master ? (div_cnt_ff == div_last) : (pclk_in && !pclk_prev_ff);

	// divider counter and pin drive; the pin is released while in slave mode
	// divide by 1, 2, 4 or 8
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_ff   <= 3'h0;
			pclk_prev_ff <= 1'b0;
			pclk_out     <= 1'b0;
			pclk_oe_n    <= 1'b1;
		end else begin
			pclk_prev_ff <= pclk_in;
			div_cnt_ff   <= (!master || div_cnt_ff >= div_last) ? 3'h0 : 3'(div_cnt_ff + 3'h1);
			// high in the first half of each period; at divide by one it stays high
			pclk_out     <= master && ((tick || div_last == 3'h0) ? 1'b1 : (3'(div_cnt_ff + 3'h1) <= (div_last >> 1)));
			pclk_oe_n    <= !master;
		end
	end

	// ************************************************************
	// the three ports
	// ************************************************************
	// three independent ports on one clock
	// per-port sequencing lives in ddc_out_port; each instance carries these rules
	// stage enables filter
	for (genvar p = 0; p < `DDC_NUM_PORTS; p++) begin : g_port
		ddc_out_port #(
			.STAGES (STAGES),
			.WORD_W (WORD_W)
		) u_port (
			.clk          (hclk),
			.rst_n        (hresetn),
			.tick         (tick),
			.enable       (port_ctrl_ff[p][`DDC_ENABLE_MSB:`DDC_ENABLE_LSB]),
			.fmt_parallel (port_ctrl_ff[p][`DDC_FORMAT_BIT]),
			.append_gain  (port_ctrl_ff[p][`DDC_APPEND_BIT]),
			.cap_valid    (stage_valid),
			.cap_i        (stage_i),
			.cap_q        (stage_q),
			.cap_g        (stage_gain),
			.ack          (port_acknowledge[p]),
			.req          (port_request[p]),
			.data         (port_data_bus[p]),
			.iq           (i_data_indicator[p]),
			.gw           (gain_word_indicator[p]),
			.src          (source_stage_index[p]),
			.pending      (pend[p])
		);
	end

endmodule : ddc_parallel_output_ports

// [ddc_port_checker_assertions.sv]
// concurrent checks on the output port block top-level pins
`timescale 1ns/10ps
`include "ddc_port_map.svh"

// ************************************************************
// checker on port pins, mostly port a; ports b and c in a few checks and covers
// ************************************************************
module ddc_port_checker #(
	parameter int STAGES = 6,
	parameter int WORD_W = 16
) (
	input wire logic                                  hclk,
	input wire logic                                  hresetn,
	input wire logic                                  pclk_out,
	input wire logic                                  pclk_oe_n,
	input wire logic [`DDC_NUM_PORTS-1:0]             port_acknowledge,
	input wire logic [`DDC_NUM_PORTS-1:0]             port_request,
	input wire logic [`DDC_NUM_PORTS-1:0][WORD_W-1:0] port_data_bus,
	input wire logic [`DDC_NUM_PORTS-1:0]             i_data_indicator,
	input wire logic [`DDC_NUM_PORTS-1:0]             gain_word_indicator,
	input wire logic [`DDC_NUM_PORTS-1:0][2:0]        source_stage_index
);
	// one domain: clock and reset given once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_boot_slave;
		$rose(hresetn) |-> pclk_oe_n && !pclk_out;
	endproperty
	a_boot_slave: assert property (p_boot_slave) else $error("clock pin driven after reset");
	// slave mode must leave the shared clock alone
	property p_slave_quiet;
		pclk_oe_n |-> !pclk_out;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("clock toggles in slave mode");
	property p_word_in_req;
		(i_data_indicator[0] || gain_word_indicator[0]) |-> port_request[0];
	endproperty
	a_word_in_req: assert property (p_word_in_req) else $error("word shown without request");
	property p_one_kind;
		(i_data_indicator & gain_word_indicator) == 3'h0;
	endproperty
	a_one_kind: assert property (p_one_kind) else $error("gain and sample flags together");
	property p_idle_quiet;
		!port_request[0] |-> port_data_bus[0] == 16'h0000 && source_stage_index[0] == 3'h0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle port not quiet");
	property p_src_range;
		source_stage_index[1] <= 3'h5;
	endproperty
	a_src_range: assert property (p_src_range) else $error("stage index out of range");
	property p_req_first;
		$rose(i_data_indicator[0]) |-> $past(port_request[0]);
	endproperty
	a_req_first: assert property (p_req_first) else $error("data before request");
	// a low acknowledge freezes the word, the i flag and the request
	property p_ack_hold;
		port_request[0] && !port_acknowledge[0] |=>
			$stable(port_data_bus[0]) && $stable(i_data_indicator[0]) && $stable(port_request[0]);
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("port moved while stalled");
	property p_req_end;
		$fell(port_request[0]) |-> !i_data_indicator[0] && !gain_word_indicator[0];
	endproperty
	a_req_end: assert property (p_req_end) else $error("request dropped with word shown");

	c_gain: cover property ($rose(gain_word_indicator[2]));
	c_b2b: cover property (i_data_indicator[1] [*4]);
	c_stall: cover property (port_request[0] && !port_acknowledge[0]);
endmodule : ddc_port_checker

bind ddc_parallel_output_ports ddc_port_checker #(.STAGES(STAGES), .WORD_W(WORD_W)) ddc_port_checker_inst (
	.hclk(hclk), .hresetn(hresetn), .pclk_out(pclk_out), .pclk_oe_n(pclk_oe_n),
	.port_acknowledge(port_acknowledge), .port_request(port_request), .port_data_bus(port_data_bus),
	.i_data_indicator(i_data_indicator), .gain_word_indicator(gain_word_indicator),
	.source_stage_index(source_stage_index));

// [ddc_port_receiver.sv]
// model of the receiving processor: acknowledge lines and an external port clock
`timescale 1ns/10ps
module ddc_port_receiver (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [2:0] stall,
	input  wire logic       run_clk,
	output logic            pclk_in,
	output logic [2:0]      port_acknowledge
);
	logic [1:0] div_ff;   // port clock divider, four system clocks a period

	// clock stands low while the bench does not ask for it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_ff <= 2'h0;
		else if (run_clk) div_ff <= div_ff + 2'h1;
		else div_ff <= 2'h0;
	end
	assign pclk_in = div_ff[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) port_acknowledge <= 3'h0;
		else port_acknowledge <= ~stall;
	end
endmodule : ddc_port_receiver

// [tb_top.sv]
// self-checking bench for the output port block
`timescale 1ns/10ps
module tb_top;
	logic             hclk = 1'b0, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic             pclk_in, pclk_out, pclk_oe_n, run_clk;
	logic [31:0]      haddr, hwdata, hrdata;
	logic [1:0]       htrans;
	logic [2:0]       hsize, stall, port_acknowledge, port_request, i_data_indicator, gain_word_indicator;
	logic [5:0]       stage_valid;
	logic [5:0][15:0] stage_i, stage_q, stage_gain;
	logic [2:0][15:0] port_data_bus;
	logic [2:0][2:0]  source_stage_index;
	int               err_count = 0;
	int               check_count = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	ddc_parallel_output_ports ddc_parallel_output_ports_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stage_valid(stage_valid), .stage_i(stage_i),
		.stage_q(stage_q), .stage_gain(stage_gain), .pclk_in(pclk_in), .pclk_out(pclk_out),
		.pclk_oe_n(pclk_oe_n), .port_acknowledge(port_acknowledge), .port_request(port_request),
		.port_data_bus(port_data_bus), .i_data_indicator(i_data_indicator),
		.gain_word_indicator(gain_word_indicator), .source_stage_index(source_stage_index));
	ddc_port_receiver ddc_port_receiver_inst (.hclk(hclk), .hresetn(hresetn), .stall(stall),
		.run_clk(run_clk), .pclk_in(pclk_in), .port_acknowledge(port_acknowledge));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one single transfer; holds each phase until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 100);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 200);
		rd = hrdata;
		if (n >= 100) chk(32'h0, 32'h1);
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask : rd_chk

	task automatic pulse(input logic [5:0] m);
		@(posedge hclk);
		stage_valid <= m;
		@(posedge hclk);
		stage_valid <= 6'h00;
	endtask : pulse

	// compare data, flags and stage index of one port at once
	task automatic word(input int p, input logic [15:0] d, input logic iq, input logic gw, input logic [2:0] s);
		chk({11'h0, i_data_indicator[p], gain_word_indicator[p], source_stage_index[p], port_data_bus[p]},
			{11'h0, iq, gw, s, d});
	endtask : word

	task automatic wait_iq(input int p);
		int n;
		n = 0;
		@(negedge hclk);
		while (i_data_indicator[p] !== 1'b1 && n < 300) begin
			@(negedge hclk);
			n++;
		end
		if (n >= 300) chk(32'h0, 32'h1);
	endtask : wait_iq

	// interleaved sample of stage 2 on port a, per = system clocks per port tick
	task automatic inter(input int per);
		wait_iq(0);
		word(0, stage_i[2], 1'b1, 1'b0, 3'h2);
		repeat (per) @(negedge hclk);
		word(0, stage_q[2], 1'b0, 1'b0, 3'h2);
		repeat (per) @(negedge hclk);
		word(0, stage_gain[2], 1'b0, 1'b1, 3'h2);
		repeat (per) @(negedge hclk);
		word(0, 16'h0000, 1'b0, 1'b0, 3'h0);
	endtask : inter

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int hi;
		for (int s = 0; s < 6; s++) begin
			stage_i[s] = 16'h80A5 + 16'(s * 256);
			stage_q[s] = 16'h7E5A + 16'(s * 512);
			stage_gain[s] = 16'h0C30 + 16'(s);
		end
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
		{stall, run_clk, stage_valid} = '0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk({31'h0, pclk_oe_n}, 32'h1);
		chk({29'h0, port_request}, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		// slave clock from the receiver, interleaved with gain on port a
		run_clk <= 1'b1;
		wr(32'h00, 32'h204);
		pulse(6'h04);
		inter(4);
		// acknowledge held low: request waits, no data moves
		stall <= 3'h1;
		pulse(6'h04);
		repeat (16) @(negedge hclk);
		word(0, 16'h0000, 1'b0, 1'b0, 3'h2);
		chk({31'h0, port_request[0]}, 32'h1);
		rd_chk(32'h10, 32'h0100_0000);
		@(posedge hclk);
		stall <= 3'h0;
		inter(4);
		run_clk <= 1'b0;
		// master clock at every divisor
		for (int d = 0; d < 4; d++) begin
			wr(32'h0C, 32'(d * 2 + 1));
			// the pin enable and the divider follow the write two edges later
			repeat (2) @(negedge hclk);
			chk({31'h0, pclk_oe_n}, 32'h0);
			hi = 0;
			repeat (1 << d) begin
				@(negedge hclk);
				hi += (pclk_out === 1'b1) ? 1 : 0;
			end
			chk(32'(hi), (d == 0) ? 32'h1 : 32'(1 << (d - 1)));
			pulse(6'h04);
			inter(1 << d);
		end
		rd_chk(32'h00, 32'h204);
		rd_chk(32'h0C, 32'h7);
		rd_chk(32'h14, 32'h0);
		// parallel format: b without gain on stages 0 and 3, c with gain on stage 1
		wr(32'h0C, 32'h3);
		wr(32'h04, 32'h109);
		wr(32'h08, 32'h302);
		pulse(6'h1B);
		fork
			begin
				wait_iq(1);
				word(1, {stage_i[0][15:8], stage_q[0][15:8]}, 1'b1, 1'b0, 3'h0);
				repeat (2) @(negedge hclk);
				word(1, {stage_i[3][15:8], stage_q[3][15:8]}, 1'b1, 1'b0, 3'h3);
				repeat (2) @(negedge hclk);
				word(1, 16'h0000, 1'b0, 1'b0, 3'h0);
			end
			begin
				wait_iq(2);
				word(2, {stage_i[1][15:8], stage_q[1][15:8]}, 1'b1, 1'b0, 3'h1);
				repeat (2) @(negedge hclk);
				word(2, stage_gain[1], 1'b0, 1'b1, 3'h1);
			end
		join
		results();
	end

	// hang guard
	initial begin
		#(25 * 8000);
		err_count++;
		results();
	end
endmodule : tb_top
